// >>> rtl/autodial_memory_sequencer.v
// Purpose : Keying procedures, number memories and line timing of a dialler
// Assumes : Keys arrive debounced as one-cycle presses; inputs synchronous
// Notes   : Waveform generation is outside; this block hands out digit codes
//
// Overview of operation
// R1 - Working register holds up to 18 positions of the number being entered.
// R2 - Entries are digits, access pauses, and six special keys in tone mode only.
// R3 - Working register goes to redial at hook-on unless a special key was used.
// R4 - Over 18 digits, or manual after automatic, clears redial at hook-on.
// R5 - German redial repeats manual numbers; general also repeats automatic ones.
// R6 - Ten repertory numbers of 18 positions; special keys are not stored.
// R7 - Extra key row gives store/recall, break, again and wait entry keys.
// R8 - User: again alone is redial; store then again is extended redial.
// R9 - User: hold store, press location, key digits; store then digit recalls.
// R10 - Pause starts by wait key, stored pause code or matched exchange prefix.
// R11 - Pause ends after 3/5 s in pulse or 1.5/2.5 s in tone, by strap.
// R12 - Dialling resumes only when hold is high; hold stuck high means no pause.
// R13 - In a pause mute holds for the hold-over time; reset delay is 320 ms.
// R14 - Two exchange prefixes of up to two digits; a match inserts a pause.
// R15 - Notepad store/store/number/store overwrites extended redial without dialling.
// R16 - Break key gives one 95 ms break; German version only in tone mode.
// R17 - Flash during dialling reinitialises and clears the working register.
// R18 - Keys 2,5,8,0 held over hook-on then hook-off clear all memory.
// R19 - Guard check failure or low supply clears all number memory.
// R20 - Four straps are read by driving the strap row and sensing columns.
// R21 - Straps select version, break ratio, long pause and long reset delay.
// R22 - Wait indicator goes low in a pause; low hold suspends dialling (here only stored playback waits for hold; keyed digits still strobe).
// R23 - Hook-off initialises the block and leaves standby.
// R24 - Line break longer than the reset delay returns to standby, memory kept.
// R25 - Unknown function key sequences return to digit entry, memory untouched.
// R26 - Stored numbers survive standby and are lost only by a memory clear.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`include "autodial_regs.vh"
module autodial_memory_sequencer #(
  parameter integer CLK_HZ   = 100000000,
  parameter integer TICK_CYC = CLK_HZ / `MS_PER_S
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Keypad
  input  wire        key_press,
  input  wire [4:0]  key_code,
  input  wire        store_recall_held,
  input  wire        clear_keys_held,
  // Line side inputs
  input  wire        hook_state_in,
  input  wire        hold_in,
  input  wire        dial_method_select,
  input  wire        power_low_in,
  input  wire        dial_busy_in,
  // Strap matrix
  input  wire [3:0]  strap_col_in,
  output wire        strap_sense_row,
  // Line side outputs
  output wire        wait_indicator_out,
  output wire        line_interrupter_out,
  output wire        mute_out,
  output wire        dial_strobe,
  output wire [4:0]  dial_code,
  output wire        break_ratio_sel
);
  // ==========================================
  // States
  localparam [3:0] S_STBY  = 4'h0, S_CHK   = 4'h1, S_CHKR  = 4'h2, S_CLR   = 4'h3;
  localparam [3:0] S_CONV  = 4'h4, S_P1    = 4'h5, S_PROG  = 4'h6, S_PFX   = 4'h7;
  localparam [3:0] S_PLAY  = 4'h8, S_PLAYR = 4'h9, S_PAUSE = 4'hA, S_FLASH = 4'hB;
  localparam [3:0] S_HANG  = 4'hC, S_COPY  = 4'hD;

  reg [3:0]  state_ff, ret_ff, slot_ff, cp_src_ff, strap_ff;
  reg [4:0]  pos_ff, cp_len_ff, first_ff, dial_code_ff;
  reg [5:0]  wr_len_ff;
  reg [1:0]  pfx_idx_ff;
  reg [4:0]  pfx_ff [0:3];
  reg [12:0] ap_ms_ff;
  reg        ph_ff, first_cyc_ff, special_ff, ovf_ff, auto_ff, man_after_ff;
  reg        pwr_fail_ff, ap_load_ff, key_lock_ff;
  reg        wait_ind_ff, line_int_ff, mute_ff, strobe_ff, row_ff;
  reg        waitreq_ff;
  reg [31:0] rdata_ff;
  reg [8:0]  mem_addr;
  reg        mem_we;
  reg [4:0]  mem_wd;
  wire [4:0] mem_rd;
  wire [12:0] ap_remain, brk_load_ms;
  wire       ap_done, brk_done;

  wire tone    = dial_method_select;
  wire general = strap_ff[`STRAP_GENERAL];
  wire kp      = key_press & ~key_lock_ff;
  wire is_dig  = (key_code < `DIGIT_LIMIT);
  wire is_spec = (key_code >= `DIGIT_LIMIT) && (key_code < `KEY_STORE);
  wire is_fn   = (key_code >= `KEY_STORE) && (key_code <= `KEY_WAIT);
  wire wr_room = (wr_len_ff < {1'b0, `MAX_POS});
  wire pos_room = (pos_ff < `MAX_POS);
  // Prefix match on the first or second manual digit
  wire pfx_hit1 = (wr_len_ff == 6'h00) &&
                  ((pfx_ff[0] == key_code && pfx_ff[1] == `CODE_END) ||
                   (pfx_ff[2] == key_code && pfx_ff[3] == `CODE_END));
  wire pfx_hit2 = (wr_len_ff == 6'h01) &&
                  ((pfx_ff[0] == first_ff && pfx_ff[1] == key_code) ||
                   (pfx_ff[2] == first_ff && pfx_ff[3] == key_code));
  // Pause length by dial mode and strap
  wire [12:0] ap_sel = tone ?
    (strap_ff[`STRAP_LONG_AP] ? `T_AP_TL_MS : `T_AP_TS_MS) :
    (strap_ff[`STRAP_LONG_AP] ? `T_AP_PL_MS : `T_AP_PS_MS);      // see R11

  // Reset delay is forced long during a pause since the line supply swaps
  assign brk_load_ms = (state_ff == S_PAUSE || strap_ff[`STRAP_LONG_RD]) ?
                       `T_RD_LONG_MS : `T_RD_SHORT_MS;             // see R13

  ms_timer #(.TICK_CYC(TICK_CYC[19:0])) u_ap_tmr (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .load (ap_load_ff),
    .load_ms (ap_ms_ff), .remain (ap_remain), .done (ap_done));

  // Reloaded while off-hook, so it only runs out over a line break
  ms_timer #(.TICK_CYC(TICK_CYC[19:0])) u_brk_tmr (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .load (hook_state_in),
    .load_ms (brk_load_ms), .remain (), .done (brk_done));

  dial_mem u_mem (
    .clk_sys (clk_sys), .addr (mem_addr), .we (mem_we), .wd (mem_wd), .rd (mem_rd));

  // ==========================================
  // Memory port steering
  always @* begin
    mem_addr = {slot_ff, pos_ff};
    mem_we   = 1'b0;
    mem_wd   = `CODE_END;
    case (state_ff)
      S_CHK: mem_addr = {`SLOT_GUARD, 5'h00};
      S_CLR: begin
        mem_we = ~ph_ff;
        mem_wd = ({slot_ff, pos_ff} == {`SLOT_GUARD, 5'h00}) ? `GUARD_VAL : `CODE_END;
      end
      S_CONV: begin
        mem_addr = {`SLOT_WORK, wr_len_ff[4:0]};
        mem_we   = kp && wr_room && (is_dig || (is_spec && tone) ||
                   key_code == `KEY_WAIT);                       // see R1, R2
        mem_wd   = (key_code == `KEY_WAIT) ? `CODE_PAUSE : key_code;
      end
      S_PROG: begin
        // Specials are dropped, function keys other than wait close the entry
        mem_we = kp && ((pos_room && (is_dig || key_code == `KEY_WAIT)) ||
                 (is_fn && key_code != `KEY_WAIT));              // see R6
        mem_wd = is_dig ? key_code : (key_code == `KEY_WAIT) ? `CODE_PAUSE : `CODE_END;
      end
      S_HANG: begin
        mem_addr = {`SLOT_REDIAL, 5'h00};
        mem_we   = ovf_ff | man_after_ff;                        // see R4
      end
      S_COPY: begin
        mem_addr = ph_ff ? {`SLOT_REDIAL, pos_ff} : {cp_src_ff, pos_ff};
        mem_we   = ph_ff;
        mem_wd   = (pos_ff == cp_len_ff) ? `CODE_END : mem_rd;
      end
      default: mem_addr = {slot_ff, pos_ff};
    endcase
  end

  // Starts an access pause: indicator low, pause timer loaded
  task start_pause;
    input [3:0] ret;
    begin
      state_ff     <= S_PAUSE;
      ret_ff       <= ret;
      wait_ind_ff  <= 1'b0;                                      // see R22
      ap_ms_ff     <= ap_sel;
      ap_load_ff   <= 1'b1;
      ph_ff        <= 1'b0;
      first_cyc_ff <= 1'b1;
    end
  endtask

  // Starts playback of a stored number
  task start_play;
    input [3:0] src;
    begin
      state_ff  <= S_PLAY;
      slot_ff   <= src;
      pos_ff    <= 5'h00;
      cp_src_ff <= src;
      cp_len_ff <= `MAX_POS;
      auto_ff   <= 1'b1;
    end
  endtask

  // Fresh working register, as at chip enable
  task init_work;
    begin
      state_ff     <= S_CONV;
      wr_len_ff    <= 6'h00;
      special_ff   <= 1'b0;
      ovf_ff       <= 1'b0;
      auto_ff      <= 1'b0;
      man_after_ff <= 1'b0;
    end
  endtask

  // ==========================================
  // Main sequencer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= S_STBY;  ret_ff <= S_CONV;  slot_ff <= 4'h0;  pos_ff <= 5'h00;
      cp_src_ff <= `SLOT_WORK;  cp_len_ff <= 5'h00;  strap_ff <= 4'h0;
      wr_len_ff <= 6'h00;  first_ff <= 5'h00;  pfx_idx_ff <= 2'h0;
      ap_ms_ff <= 13'h0000;  ap_load_ff <= 1'b0;  ph_ff <= 1'b0;
      first_cyc_ff <= 1'b0;  special_ff <= 1'b0;  ovf_ff <= 1'b0;
      auto_ff <= 1'b0;  man_after_ff <= 1'b0;  pwr_fail_ff <= 1'b0;
      wait_ind_ff <= 1'b1;  line_int_ff <= 1'b0;  mute_ff <= 1'b0;
      strobe_ff <= 1'b0;  dial_code_ff <= 5'h00;  row_ff <= 1'b0;
    end else begin
      ap_load_ff <= 1'b0;
      strobe_ff  <= 1'b0;
      if (power_low_in) begin
        pwr_fail_ff <= 1'b1;                                     // see R19
      end
      // Mute: pause hold-over, flash, programming, digit output
      mute_ff <= (state_ff == S_PAUSE && (first_cyc_ff || (!ph_ff &&
                  ap_remain > ap_ms_ff - `T_HOLDOVER_MS))) ||    // see R13
                 state_ff == S_FLASH || state_ff == S_PROG || state_ff == S_PFX ||
                 ((dial_busy_in || strobe_ff) && hold_in);       // see R22
      if (!hook_state_in && brk_done && state_ff != S_STBY &&
          state_ff != S_HANG && state_ff != S_COPY) begin
        // Long line break: back to standby, memory kept
        state_ff    <= S_HANG;                                   // see R24
        wait_ind_ff <= 1'b1;
        line_int_ff <= 1'b0;
      end else begin
        case (state_ff)
          S_STBY: if (hook_state_in) begin
            state_ff <= S_CHK;                                   // see R23
            row_ff   <= 1'b1;
          end
          S_CHK: state_ff <= S_CHKR;
          S_CHKR: begin
            strap_ff <= strap_col_in;                            // see R20, R21
            row_ff   <= 1'b0;
            slot_ff  <= 4'h0;
            pos_ff   <= 5'h00;
            ph_ff    <= 1'b0;
            // Clear keys held, a power failure or a bad guard word clear memory
            if (!clear_keys_held && !pwr_fail_ff && mem_rd == `GUARD_VAL) begin
              init_work;
            end else begin
              state_ff <= S_CLR;                                 // see R18, R19
            end
          end
          S_CLR: begin
            if (!ph_ff) begin
              {slot_ff, pos_ff} <= {slot_ff, pos_ff} + 9'h001;
              if ({slot_ff, pos_ff} == 9'h1FF) begin
                ph_ff       <= 1'b1;
                pwr_fail_ff <= power_low_in;
                pfx_ff[0] <= `CODE_END;  pfx_ff[1] <= `CODE_END;
                pfx_ff[2] <= `CODE_END;  pfx_ff[3] <= `CODE_END;
              end
            end else if (!clear_keys_held) begin
              init_work;                                         // see R18
            end
          end
          S_CONV: if (kp) begin
            if (is_dig || (is_spec && tone)) begin
              strobe_ff    <= 1'b1;
              dial_code_ff <= key_code;
              if (wr_len_ff != `MAX_DIGITS) begin
                wr_len_ff <= wr_len_ff + 6'h01;
              end
              if (!wr_room) begin
                ovf_ff <= 1'b1;                                  // see R4
              end
              if (is_spec) begin
                special_ff <= 1'b1;                              // see R3
              end
              if (auto_ff) begin
                man_after_ff <= 1'b1;                            // see R4
              end
              if (wr_len_ff == 6'h00) begin
                first_ff <= key_code;
              end
              if (is_dig && (pfx_hit1 || pfx_hit2)) begin
                start_pause(S_CONV);                             // see R10, R14
              end
            end else if (key_code == `KEY_WAIT) begin
              if (wr_room) begin
                wr_len_ff <= wr_len_ff + 6'h01;
              end
              start_pause(S_CONV);                               // see R10
            end else if (key_code == `KEY_STORE) begin
              state_ff <= S_P1;                                  // see R7
            end else if (key_code == `KEY_AGAIN) begin
              start_play(`SLOT_REDIAL);                          // see R5, R8
            end else if (key_code == `KEY_BREAK && (general || tone)) begin
              state_ff     <= S_FLASH;                           // see R16
              line_int_ff  <= 1'b1;
              ap_ms_ff     <= `T_FLASH_MS;
              ap_load_ff   <= 1'b1;
              first_cyc_ff <= 1'b1;
            end
          end
          S_P1: if (kp) begin
            state_ff <= S_CONV;                                  // see R25
            if (is_dig && store_recall_held) begin
              state_ff <= S_PROG;                                // see R9
              slot_ff  <= key_code[3:0];
              pos_ff   <= 5'h00;
            end else if (is_dig) begin
              start_play(key_code[3:0]);                         // see R9
            end else if (key_code == `KEY_AGAIN && store_recall_held) begin
              state_ff   <= S_PFX;                               // see R14
              pfx_idx_ff <= 2'h0;
              pfx_ff[0] <= `CODE_END;  pfx_ff[1] <= `CODE_END;
              pfx_ff[2] <= `CODE_END;  pfx_ff[3] <= `CODE_END;
            end else if (key_code == `KEY_AGAIN) begin
              start_play(`SLOT_EXT);                             // see R8
            end else if (key_code == `KEY_STORE) begin
              state_ff <= S_PROG;                                // see R15
              slot_ff  <= `SLOT_EXT;
              pos_ff   <= 5'h00;
            end
          end
          S_PROG: if (kp) begin
            if ((is_dig || key_code == `KEY_WAIT) && pos_room) begin
              pos_ff <= pos_ff + 5'h01;                          // see R6
            end else if (is_fn && key_code != `KEY_WAIT) begin
              state_ff <= S_CONV;                                // see R15
            end
          end
          S_PFX: if (kp) begin
            if (is_dig) begin
              pfx_ff[pfx_idx_ff] <= key_code;
              pfx_idx_ff <= pfx_idx_ff + 2'h1;
              if (pfx_idx_ff == 2'h3) begin
                state_ff <= S_CONV;
              end
            end else if (key_code == `KEY_AGAIN && !pfx_idx_ff[1]) begin
              pfx_idx_ff <= 2'h2;                                // see R14
            end else if (!is_spec) begin
              state_ff <= S_CONV;
            end
          end
          S_PLAY: if (!dial_busy_in && !strobe_ff && hold_in) begin
            state_ff <= S_PLAYR;                                 // see R12, R22
          end
          S_PLAYR: begin
            pos_ff <= pos_ff + 5'h01;
            if (mem_rd == `CODE_END || pos_ff == `MAX_POS) begin
              state_ff <= S_CONV;
            end else if (mem_rd == `CODE_PAUSE) begin
              start_pause(S_PLAY);                               // see R10
            end else begin
              strobe_ff    <= 1'b1;
              dial_code_ff <= mem_rd;
              state_ff     <= S_PLAY;
            end
          end
          S_PAUSE: begin
            first_cyc_ff <= 1'b0;
            if (first_cyc_ff && hold_in) begin
              wait_ind_ff <= 1'b1;                               // see R12
              state_ff    <= ret_ff;
            end else if (!first_cyc_ff && !ph_ff && ap_done) begin
              wait_ind_ff <= 1'b1;                               // see R11
              ph_ff       <= 1'b1;
            end else if (ph_ff && hold_in) begin
              state_ff <= ret_ff;                                // see R12
            end
          end
          S_FLASH: begin
            first_cyc_ff <= 1'b0;
            if (!first_cyc_ff && ap_done) begin
              line_int_ff <= 1'b0;
              init_work;                                         // see R17
            end
          end
          S_HANG: begin
            pos_ff   <= 5'h00;
            ph_ff    <= 1'b0;
            state_ff <= S_STBY;                                  // see R26
            if (!(ovf_ff || man_after_ff || special_ff)) begin
              if (auto_ff && general) begin
                state_ff <= S_COPY;                              // see R5
              end else if (!auto_ff && wr_len_ff != 6'h00) begin
                state_ff  <= S_COPY;                             // see R3
                cp_src_ff <= `SLOT_WORK;
                cp_len_ff <= wr_len_ff[4:0];
              end
            end
          end
          S_COPY: begin
            ph_ff <= ~ph_ff;
            if (ph_ff) begin
              pos_ff <= pos_ff + 5'h01;
              if (pos_ff == cp_len_ff || mem_rd == `CODE_END) begin
                state_ff <= S_STBY;
              end
            end
          end
          default: state_ff <= S_STBY;
        endcase
      end
    end
  end

  // ==========================================
  // Avalon slave: one wait cycle, then a single answer cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      waitreq_ff  <= 1'b1;
      rdata_ff    <= 32'h00000000;
      key_lock_ff <= 1'b0;
    end else begin
      waitreq_ff <= 1'b1;
      // Write lands at the answer edge
      if (avs_write && !waitreq_ff && avs_address == `OFS_CTRL) begin
        key_lock_ff <= avs_writedata[`CTRL_KEY_LOCK];
      end
      if ((avs_read || avs_write) && waitreq_ff) begin
        waitreq_ff <= 1'b0;
        case (avs_address)
          `OFS_CTRL:   rdata_ff <= {31'h00000000, key_lock_ff};
          `OFS_STATUS: rdata_ff <= {16'h0000, ovf_ff, special_ff, wr_len_ff,
                                    strap_ff, state_ff};
          `OFS_PREFIX: rdata_ff <= {12'h000, pfx_ff[3], pfx_ff[2], pfx_ff[1], pfx_ff[0]};
          default:     rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_readdata         = rdata_ff;
  assign avs_waitrequest      = waitreq_ff;
  assign strap_sense_row      = row_ff;
  assign wait_indicator_out   = wait_ind_ff;
  assign line_interrupter_out = line_int_ff;
  assign mute_out             = mute_ff;
  assign dial_strobe          = strobe_ff;
  assign dial_code            = dial_code_ff;
  assign break_ratio_sel      = strap_ff[`STRAP_RATIO];
endmodule // autodial_memory_sequencer

// >>> rtl/autodial_regs.vh
// Purpose : Shared constants for the autodial memory sequencer
// Assumes : 100 MHz clk_sys, millisecond timebase derived from it
// Notes   : Times are in ms; cycle counts derive from the clock rate
`ifndef AUTODIAL_REGS_VH
`define AUTODIAL_REGS_VH
// ==========================================
// Register offsets (byte addresses)
`define OFS_CTRL      4'h0
`define OFS_STATUS    4'h4
`define OFS_PREFIX    4'h8
`define CTRL_KEY_LOCK 0
// ==========================================
// Key and stored codes
`define KEY_STORE     5'h10
`define KEY_BREAK     5'h11
`define KEY_AGAIN     5'h12
`define KEY_WAIT      5'h13
`define CODE_PAUSE    5'h14
`define CODE_END      5'h1F
`define DIGIT_LIMIT   5'h0A
// ==========================================
// Memory slots and sizes
`define SLOT_WORK     4'hA
`define SLOT_REDIAL   4'hB
`define SLOT_EXT      4'hC
`define SLOT_GUARD    4'hF
`define GUARD_VAL     5'h15
`define MAX_POS       5'h12
`define MAX_DIGITS    6'h24
// ==========================================
// Strap bit positions (column 1..4)
`define STRAP_RATIO   0
`define STRAP_LONG_AP 1
`define STRAP_LONG_RD 2
`define STRAP_GENERAL 3
// ==========================================
// Times in ms
`define T_FLASH_MS    13'h005F
`define T_RD_SHORT_MS 13'h00A0
`define T_RD_LONG_MS  13'h0140
`define T_AP_PS_MS    13'h0BB8
`define T_AP_PL_MS    13'h1388
`define T_AP_TS_MS    13'h05DC
`define T_AP_TL_MS    13'h09C4
`define T_HOLDOVER_MS 13'h03E8
`define MS_PER_S      1000
`endif

// >>> rtl/dial_mem.v
// Purpose : Number store, 16 slots of 32 positions, 5-bit codes
// Assumes : Single port, read first (a write returns the old data), read data one edge later
// Notes   : No reset; contents survive standby and system reset
`timescale 1ns/100ps
module dial_mem (
  // Clock
  input  wire       clk_sys,
  // Access
  input  wire [8:0] addr,
  input  wire       we,
  input  wire [4:0] wd,
  output wire [4:0] rd
);
  reg [4:0] ram [0:511];
  reg [4:0] rd_ff;

  // Registered read keeps the output free of address glitches
  always @(posedge clk_sys) begin
    if (we) begin
      ram[addr] <= wd;
    end
    rd_ff <= ram[addr];
  end

  assign rd = rd_ff;
endmodule // dial_mem

// >>> rtl/ms_timer.v
// Purpose : Millisecond down counter with load
// Assumes : TICK_CYC clock cycles make one millisecond
// Notes   : Load restarts the prescaler so the first ms is full length
`timescale 1ns/100ps
module ms_timer #(
  parameter [19:0] TICK_CYC = 20'h186A0
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Control
  input  wire        load,
  input  wire [12:0] load_ms,
  // Status
  output wire [12:0] remain,
  output wire        done
);
  reg [19:0] pre_ff;
  reg [12:0] cnt_ff;

  // Prescaler and down count; holds at zero
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_ff <= 20'h00000;
      cnt_ff <= 13'h0000;
    end else if (load) begin
      pre_ff <= 20'h00000;
      cnt_ff <= load_ms;
    end else if (pre_ff == TICK_CYC - 20'h00001) begin
      pre_ff <= 20'h00000;
      if (cnt_ff != 13'h0000) begin
        cnt_ff <= cnt_ff - 13'h0001;
      end
    end else begin
      pre_ff <= pre_ff + 20'h00001;
    end
  end

  assign remain = cnt_ff;
  assign done   = (cnt_ff == 13'h0000);
endmodule // ms_timer

// >>> test/autodial_monitor.sv
// Purpose: port checks of the sequencer
// Assumes: one clock. Notes: hold tied to the wait output
`timescale 1ns/100ps
`include "autodial_regs.vh"
module autodial_monitor #(parameter integer TICK_CYC = 10) (
  // Watched ports
  input wire clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, key_press, hold_in,
  input wire dial_method_select, strap_sense_row, wait_indicator_out, line_interrupter_out,
  input wire mute_out, dial_strobe,
  input wire break_ratio_sel,
  input wire [4:0] key_code,
  input wire [3:0] strap_col_in);
  int ap = 0;
  // Pause length; a counter, since repetitions this long stall tools
  always @(posedge clk_sys) ap <= wait_indicator_out ? 0 : ap + 1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  a_bus_answer: assert property (s_req |=> !avs_waitrequest) else $error("bus");
  a_strobe_one: assert property (dial_strobe |=> !dial_strobe) else $error("strobe");
  a_special_drop: assert property (!dial_method_select && key_press &&
    key_code inside {[5'h0A:5'h0F]} |=> !dial_strobe) else $error("special");
  a_ratio_strap: assert property (strap_sense_row |-> ##2
    break_ratio_sel == strap_col_in[0]) else $error("ratio");
  a_flash_mode: assert property ($rose(line_interrupter_out) |->
    dial_method_select || strap_col_in[3]) else $error("flash");
  a_pause_len: assert property ($rose(wait_indicator_out) && ap > 4 &&
    dial_method_select && !strap_col_in[1] |->
    ap + 1 >= `T_AP_TS_MS * TICK_CYC && ap <= `T_AP_TS_MS * TICK_CYC + 3) else $error("pause");
  a_pause_mute: assert property ($fell(wait_indicator_out) |=> mute_out[*8])
    else $error("mute");
  a_hold_stop: assert property (dial_strobe |-> $past(hold_in)) else $error("hold");
endmodule // autodial_monitor
bind autodial_memory_sequencer autodial_monitor #(.TICK_CYC(TICK_CYC)) mon (.*);

// >>> test/line_partner.sv
// Purpose: far side, digit generator busy and hold strap
// Assumes: one clock. Notes: busy four cycles per digit
`timescale 1ns/100ps
module line_partner (
  // Dialler side
  input wire clk_sys, dial_strobe, wait_indicator_out,
  output wire dial_busy_in, hold_in);
  logic [2:0] busy_ff = 3'h0;
  assign hold_in = wait_indicator_out;
  // Busy from the cycle after a strobe, like a tone burst
  always @(posedge clk_sys) busy_ff <= dial_strobe === 1'h1 ? 3'h4 : busy_ff - {2'h0, |busy_ff};
  assign dial_busy_in = |busy_ff;
endmodule // line_partner

// >>> test/tb_autodial_memory_sequencer.sv
// Purpose: directed test of the sequencer
// Assumes: TICK_CYC 10. Notes: straps give general version
`timescale 1ns/100ps
`include "autodial_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_autodial_memory_sequencer;
  logic clk_sys = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, key_press = 1'h0;
  logic hook_state_in = 1'h0, dial_method_select = 1'h0, store_recall_held = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [4:0] key_code = 5'h00, last_code;
  logic [31:0] avs_writedata = 32'h0, rd;
  wire [31:0] avs_readdata;
  wire [4:0] dial_code;
  wire avs_waitrequest, dial_busy_in, hold_in, wait_indicator_out, line_interrupter_out;
  wire mute_out, dial_strobe, break_ratio_sel, strap_sense_row;
  int n_mismatch = 0, checked = 0, n_strobe = 0, c;
  // Straps 9: general version, long break ratio
  autodial_memory_sequencer #(.TICK_CYC(10)) dut (.*,
    .clear_keys_held(1'h0), .power_low_in(1'h0), .strap_col_in(4'h9));
  line_partner far (.*);
  // Clock
  initial forever #5 clk_sys = ~clk_sys;
  // Digit log
  always @(posedge clk_sys) if (dial_strobe === 1'h1) begin
    n_strobe++;
    last_code = dial_code;
  end
  // Request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
  endtask
  task key(input logic [4:0] k);
    @(posedge clk_sys);
    {key_press, key_code} <= {1'h1, k};
    @(posedge clk_sys);
    key_press <= 1'h0;
    repeat (10) @(posedge clk_sys);
  endtask
  task stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog, twice the planned run
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    stop_test;
  end
  // Tests
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    bus(1'h1, `OFS_CTRL, 32'h1);
    bus(1'h0, `OFS_CTRL, 32'h0);
    `CHK(rd[0], 1'h1)
    bus(1'h1, `OFS_CTRL, 32'h0);
    bus(1'h0, 4'hC, 32'h0);
    `CHK(rd, 32'h0)
    $display("regs done");
    hook_state_in <= 1'h1;
    do bus(1'h0, `OFS_STATUS, 32'h0); while (rd[3:0] !== 4'h4);
    key(5'h03);
    key(5'h0A);
    bus(1'h0, `OFS_STATUS, 32'h0);
    `CHK({n_strobe[1:0], last_code, rd[13:4], break_ratio_sel}, {2'h1, 5'h03, 6'h01, 4'h9, 1'h1})
    $display("dial done");
    store_recall_held <= 1'h1;
    key(`KEY_STORE);
    key(5'h01);
    store_recall_held <= 1'h0;
    key(5'h07);
    key(`KEY_STORE);
    key(`KEY_STORE);
    key(5'h01);
    `CHK({n_strobe[1:0], last_code}, {2'h2, 5'h07})
    key(`KEY_STORE);
    key(`KEY_STORE);
    key(5'h05);
    key(`KEY_STORE);
    key(`KEY_STORE);
    key(`KEY_AGAIN);
    `CHK({n_strobe[1:0], last_code}, {2'h3, 5'h05})
    $display("mem done");
    dial_method_select <= 1'h1;
    key(`KEY_WAIT);
    `CHK({wait_indicator_out, mute_out}, 2'h1)
    for (c = 5; wait_indicator_out !== 1'h1; c++) @(posedge clk_sys);
    `CHK(c > 14990 && c < 15010, 1'h1)
    key(`KEY_BREAK);
    for (c = 5; line_interrupter_out !== 1'h0; c++) @(posedge clk_sys);
    bus(1'h0, `OFS_STATUS, 32'h0);
    `CHK({c > 940 && c < 960, rd[13:8]}, 7'h40)
    $display("line done");
    hook_state_in <= 1'h0;
    do bus(1'h0, `OFS_STATUS, 32'h0); while (rd[3:0] !== 4'h0);
    $display("hang done");
    stop_test;
  end
endmodule // tb_autodial_memory_sequencer
